// ==== pph_pkg.sv ====
// Purpose: Constants for the parallel port handshake block
// Assumes: 100 MHz clk, synchronous active-high rst
// Notes:   Register index equals byte offset on the plain port
// Overview of operation
// - Ports 0, 1, 2 each choose input or output handshake independently.
// - Falling edge of a port's incoming line raises that port's request.
// - Writing a byte in output handshake drives the data valid strobe low.
// - After a write the strobe stays high until acknowledge is high.
// - Acknowledge low returns the strobe high until the next write.
// - First byte after setup also waits for acknowledge high before the strobe falls.
// - Input handshake: lower direction bit set, upper clear; port 2 bit 7 set.
// - Output handshake: both direction bits clear; port 2 bit 7 clear.
// - Handshake enabled by aux mode bits 2; 3 and 4; 5 per port.
package pph_pkg;
  localparam int          ADDR_W        = 4;
  localparam int          NUM_PORTS     = 3;
  localparam logic [3:0]  OFS_PORT0     = 4'h0;
  localparam logic [3:0]  OFS_PORT1     = 4'h1;
  localparam logic [3:0]  OFS_PORT2     = 4'h2;
  localparam logic [3:0]  OFS_AUX_OUT   = 4'h3;
  localparam logic [3:0]  OFS_P01_DIR   = 4'h4;
  localparam logic [3:0]  OFS_P2_DIR    = 4'h5;
  localparam logic [3:0]  OFS_AUX_MODE  = 4'h6;
  localparam logic [3:0]  OFS_IRQ_STAT  = 4'h7;
  localparam logic [3:0]  OFS_IRQ_MASK  = 4'h8;
  localparam logic [3:0]  OFS_HS_STAT   = 4'h9;
  // Direction bit positions (lower, upper) in the shared port 0/1 register; port 2 uses one bit of its own register
  localparam int          P0_DIR_LO     = 6;
  localparam int          P0_DIR_HI     = 7;
  localparam int          P1_DIR_LO     = 3;
  localparam int          P1_DIR_HI     = 4;
  localparam int          P2_DIR_BIT    = 7;
  // Aux mode enables and aux output strobe bits
  localparam int          P0_EN_BIT     = 2;
  localparam int          P1_EN_BIT_A   = 3;
  localparam int          P1_EN_BIT_B   = 4;
  localparam int          P2_EN_BIT     = 5;
  localparam int          P0_AUX_BIT    = 5;
  localparam int          P1_AUX_BIT    = 4;
  localparam int          P2_AUX_BIT    = 6;
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [7:0]  RST_AUX_OUT   = 8'hFF;
  localparam logic [7:0]  RST_P01_DIR   = 8'hD8;
  localparam logic [7:0]  RST_P2_DIR    = 8'hFF;
  localparam int          SYNC_STAGES   = 3;
endpackage

// ==== pph_chan_if.sv ====
// Purpose: Carrier between the register side and one handshake channel
// Assumes: Same clock on both sides
// Notes:   wr, rd, line_fall and req are single-cycle pulses; hs_line is a level
`timescale 1ns/100ps
interface pph_chan_if;
  logic       en;
  logic       dir_in;
  logic       wr;
  logic [7:0] wdata;
  logic       rd;
  logic       line_lvl;
  logic       line_fall;
  logic [7:0] pin_data;
  logic       hs_line;
  logic [7:0] data_q;
  logic       req;
  modport ctl
  (
    output en, dir_in, wr, wdata, rd, line_lvl, line_fall, pin_data,
    input  hs_line, data_q, req
  );
  modport chan
  (
    input  en, dir_in, wr, wdata, rd, line_lvl, line_fall, pin_data,
    output hs_line, data_q, req
  );
endinterface // pph_chan_if

// ==== pph_chan.sv ====
// Purpose: One port's strobe/acknowledge engine
// Assumes: line_lvl and line_fall already synchronised
// Notes:   hs_line is the level the device drives on its outgoing line
`timescale 1ns/100ps
module pph_chan
(
  input  wire logic   clk,
  input  wire logic   rst,
  pph_chan_if.chan    cif
);
  typedef enum logic [1:0] {ST_IDLE, ST_DEFER, ST_VALID, ST_HELD} pph_state_t;

  pph_state_t state;
  pph_state_t next_state;
  logic [7:0] data_q;
  logic [7:0] next_data_q;

  always_comb
  begin
    next_state  = state;
    next_data_q = data_q;
    if (cif.wr)
      next_data_q = cif.wdata;
    case (state)
      ST_IDLE:
      begin
        if (cif.wr && !cif.dir_in)
          next_state = ST_DEFER;
        else if (cif.dir_in && cif.line_fall)
        begin
          next_data_q = cif.pin_data;
          next_state  = ST_HELD;
        end
      end
      ST_DEFER:
        if (cif.line_lvl)
          next_state = ST_VALID;
      ST_VALID:
        if (cif.line_fall)
          next_state = ST_IDLE;
      ST_HELD:
        if (cif.rd)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
    // Disable, or a mode change that clears en, abandons any transfer in flight
    if (!cif.en)
      next_state = ST_IDLE;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state  <= ST_IDLE;
      data_q <= pph_pkg::RST_BYTE;
    end
    else
    begin
      state  <= next_state;
      data_q <= next_data_q;
    end
  end

  // Strobe low only in VALID; ready low while a received byte is unread
  assign cif.hs_line = (state != ST_VALID) && (state != ST_HELD);
  assign cif.data_q  = data_q;
  assign cif.req     = cif.en && cif.line_fall;
endmodule // pph_chan

// ==== pph_top.sv ====
// Purpose: Handshake logic for three 8-bit parallel ports
// Assumes: Plain register port, read data valid the cycle after rd
// Notes:   Outgoing line follows the aux output bit while handshake is off
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/100ps
module pph_top
(
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic [pph_pkg::ADDR_W-1:0] addr,
  input  wire logic [7:0]                 wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic [7:0]                      rdata,
  input  wire logic [2:0]                 hs_in,
  output logic [2:0]                      hs_out,
  input  wire logic [23:0]                port_in,
  output logic [23:0]                     port_out,
  output logic [23:0]                     port_oe,
  output logic                            port0_request,
  output logic                            port1_request,
  output logic                            port2_request,
  output logic                            irq
);
  localparam int NP = pph_pkg::NUM_PORTS;

  logic [7:0]    aux_out;
  logic [7:0]    next_aux_out;
  logic [7:0]    port01_direction_reg;
  logic [7:0]    next_port01_direction_reg;
  logic [7:0]    port2_direction_reg;
  logic [7:0]    next_port2_direction_reg;
  logic [7:0]    aux_port_mode_reg;
  logic [7:0]    next_aux_port_mode_reg;
  logic [NP-1:0] irq_stat;
  logic [NP-1:0] next_irq_stat;
  logic [NP-1:0] irq_mask;
  logic [NP-1:0] next_irq_mask;
  logic [7:0]    rdata_q;
  logic [7:0]    next_rdata_q;
  logic [7:0]    out_q [NP];
  logic [7:0]    next_out_q [NP];

  logic [NP-1:0] en;
  logic [NP-1:0] dir_in;
  logic [NP-1:0] dir_out;
  logic [NP-1:0] aux_bit;
  logic [NP-1:0] line_lvl;
  logic [NP-1:0] req;
  logic [NP-1:0] hs_line;
  logic [7:0]    data_q [NP];

  // Mode decode; address/data or mixed settings leave handshake off
  always_comb
  begin
    dir_in[0]  = port01_direction_reg[pph_pkg::P0_DIR_LO] && !port01_direction_reg[pph_pkg::P0_DIR_HI];
    dir_out[0] = !port01_direction_reg[pph_pkg::P0_DIR_LO] && !port01_direction_reg[pph_pkg::P0_DIR_HI];
    dir_in[1]  = port01_direction_reg[pph_pkg::P1_DIR_LO] && !port01_direction_reg[pph_pkg::P1_DIR_HI];
    dir_out[1] = !port01_direction_reg[pph_pkg::P1_DIR_LO] && !port01_direction_reg[pph_pkg::P1_DIR_HI];
    dir_in[2]  = port2_direction_reg[pph_pkg::P2_DIR_BIT];
    dir_out[2] = !port2_direction_reg[pph_pkg::P2_DIR_BIT];
    en[0] = aux_port_mode_reg[pph_pkg::P0_EN_BIT] && (dir_in[0] || dir_out[0]);
    en[1] = aux_port_mode_reg[pph_pkg::P1_EN_BIT_A] && aux_port_mode_reg[pph_pkg::P1_EN_BIT_B]
            && (dir_in[1] || dir_out[1]);
    en[2] = aux_port_mode_reg[pph_pkg::P2_EN_BIT];
    aux_bit[0] = aux_out[pph_pkg::P0_AUX_BIT];
    aux_bit[1] = aux_out[pph_pkg::P1_AUX_BIT];
    aux_bit[2] = aux_out[pph_pkg::P2_AUX_BIT];
  end

  genvar g;
  generate
    for (g = 0; g < NP; g++)
    begin : g_port
      logic [pph_pkg::SYNC_STAGES-1:0] sync_q;
      logic [pph_pkg::SYNC_STAGES-1:0] next_sync_q;
      logic                            stable;
      logic                            next_stable;
      pph_chan_if                      cif ();

      // Level counts once stages two and three agree
      always_comb
      begin
        next_sync_q = {sync_q[pph_pkg::SYNC_STAGES-2:0], hs_in[g]};
        next_stable = (sync_q[1] == sync_q[2]) ? sync_q[2] : stable;
      end

      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          sync_q <= '1;
          stable <= 1'b1;
        end
        else
        begin
          sync_q <= next_sync_q;
          stable <= next_stable;
        end
      end

      assign cif.en        = en[g];
      assign cif.dir_in    = dir_in[g];
      assign cif.wr        = wr && (addr == pph_pkg::ADDR_W'(g));
      assign cif.wdata     = wdata;
      assign cif.rd        = rd && (addr == pph_pkg::ADDR_W'(g));
      assign cif.line_lvl  = stable;
      assign cif.line_fall = stable && !next_stable;
      assign cif.pin_data  = port_in[g*8 +: 8];
      assign line_lvl[g]   = stable;
      assign req[g]        = cif.req;
      assign hs_line[g]    = cif.hs_line;
      assign data_q[g]     = cif.data_q;

      pph_chan u_chan
      (
        .clk (clk),
        .rst (rst),
        .cif (cif)
      );

      // Before enable the line carries the aux bit, which software sets high
      assign hs_out[g]        = en[g] ? hs_line[g] : aux_bit[g];
      assign port_out[g*8 +: 8] = out_q[g];
      assign port_oe[g*8 +: 8]  = dir_out[g] ? 8'hFF : 8'h00;
    end
  endgenerate

  always_comb
  begin
    next_aux_out              = aux_out;
    next_port01_direction_reg = port01_direction_reg;
    next_port2_direction_reg  = port2_direction_reg;
    next_aux_port_mode_reg    = aux_port_mode_reg;
    next_irq_mask             = irq_mask;
    next_irq_stat             = irq_stat;
    next_rdata_q              = 8'h00;
    for (int i = 0; i < NP; i++)
    begin
      next_out_q[i] = out_q[i];
      if (wr && addr == pph_pkg::ADDR_W'(i))
        next_out_q[i] = wdata;
    end
    if (wr)
    begin
      case (addr)
        pph_pkg::OFS_AUX_OUT:  next_aux_out              = wdata;
        pph_pkg::OFS_P01_DIR:  next_port01_direction_reg = wdata;
        pph_pkg::OFS_P2_DIR:   next_port2_direction_reg  = wdata;
        pph_pkg::OFS_AUX_MODE: next_aux_port_mode_reg    = wdata;
        pph_pkg::OFS_IRQ_STAT: next_irq_stat             = irq_stat & ~wdata[NP-1:0];
        pph_pkg::OFS_IRQ_MASK: next_irq_mask             = wdata[NP-1:0];
        default:               next_aux_out              = aux_out;
      endcase
    end
    // A request in the clearing cycle survives
    next_irq_stat = next_irq_stat | req;
    if (rd)
    begin
      case (addr)
        pph_pkg::OFS_PORT0:    next_rdata_q = data_q[0];
        pph_pkg::OFS_PORT1:    next_rdata_q = data_q[1];
        pph_pkg::OFS_PORT2:    next_rdata_q = data_q[2];
        pph_pkg::OFS_AUX_OUT:  next_rdata_q = aux_out;
        pph_pkg::OFS_P01_DIR:  next_rdata_q = port01_direction_reg;
        pph_pkg::OFS_P2_DIR:   next_rdata_q = port2_direction_reg;
        pph_pkg::OFS_AUX_MODE: next_rdata_q = aux_port_mode_reg;
        pph_pkg::OFS_IRQ_STAT: next_rdata_q = {5'h00, irq_stat};
        pph_pkg::OFS_IRQ_MASK: next_rdata_q = {5'h00, irq_mask};
        pph_pkg::OFS_HS_STAT:  next_rdata_q = {2'h0, hs_out, line_lvl};
        default:               next_rdata_q = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      aux_out              <= pph_pkg::RST_AUX_OUT;
      port01_direction_reg <= pph_pkg::RST_P01_DIR;
      port2_direction_reg  <= pph_pkg::RST_P2_DIR;
      aux_port_mode_reg    <= pph_pkg::RST_BYTE;
      irq_stat             <= '0;
      irq_mask             <= '0;
      rdata_q              <= pph_pkg::RST_BYTE;
      for (int i = 0; i < NP; i++)
        out_q[i] <= pph_pkg::RST_BYTE;
    end
    else
    begin
      aux_out              <= next_aux_out;
      port01_direction_reg <= next_port01_direction_reg;
      port2_direction_reg  <= next_port2_direction_reg;
      aux_port_mode_reg    <= next_aux_port_mode_reg;
      irq_stat             <= next_irq_stat;
      irq_mask             <= next_irq_mask;
      rdata_q              <= next_rdata_q;
      for (int i = 0; i < NP; i++)
        out_q[i] <= next_out_q[i];
    end
  end

  assign rdata         = rdata_q;
  assign port0_request = req[0];
  assign port1_request = req[1];
  assign port2_request = req[2];
  assign irq           = |(irq_stat & irq_mask);
endmodule // pph_top

// ==== pph_periph.sv ====
// Purpose: Peripheral that takes bytes from the output handshake
// Assumes: Strobe low means the byte on data is valid
// Notes:   slow adds a six-cycle think time to every ack edge
`timescale 1ns/100ps
module pph_periph
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       strobe_n,
  input  wire logic [7:0] data,
  input  wire logic       hold,
  input  wire logic       slow,
  output logic            ack,
  output logic [7:0]      got
);
  int wait_cnt;
  always @(posedge clk)
  begin
    if (rst)
    begin
      ack      <= 1'b1;
      wait_cnt <= 0;
    end
    else if (hold)
    begin
      ack      <= 1'b0;
      wait_cnt <= 0;
    end
    else if (ack == !strobe_n)
    begin
      // Latch once on strobe low, before ack moves
      if (wait_cnt == 0 && !strobe_n)
        got <= data;
      if (wait_cnt == (slow ? 6 : 0))
      begin
        ack      <= strobe_n;
        wait_cnt <= 0;
      end
      else
        wait_cnt <= wait_cnt + 1;
    end
  end
endmodule // pph_periph

// ==== pph_checker.sv ====
// Purpose: Port-level checks of the handshake block
// Assumes: Mode state is mirrored from writes on the plain port
// Notes:   Stimulus must not toggle a line while its port is being enabled
`timescale 1ns/100ps
module pph_checker
(
  input wire logic                       clk,
  input wire logic                       rst,
  input wire logic [pph_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0]                 wdata,
  input wire logic                       wr,
  input wire logic [2:0]                 hs_in,
  input wire logic [2:0]                 hs_out,
  input wire logic [23:0]                port_oe,
  input wire logic                       port0_request,
  input wire logic                       port2_request
);
  logic [7:0] d01;
  logic [7:0] d2;
  logic [7:0] aux;
  logic [7:0] mode;
  logic       p2en;
  logic       p2o;
  logic       p0i;
  assign p2en = mode[5];
  assign p2o  = p2en && !d2[7];
  assign p0i  = mode[2] && d01[7:6] == 2'b01;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      d01  <= pph_pkg::RST_P01_DIR;
      d2   <= pph_pkg::RST_P2_DIR;
      aux  <= pph_pkg::RST_AUX_OUT;
      mode <= pph_pkg::RST_BYTE;
    end
    else if (wr)
    begin
      if (addr == pph_pkg::OFS_P01_DIR) d01 <= wdata;
      if (addr == pph_pkg::OFS_P2_DIR) d2 <= wdata;
      if (addr == pph_pkg::OFS_AUX_OUT) aux <= wdata;
      if (addr == pph_pkg::OFS_AUX_MODE) mode <= wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  oe_decode_a:
    assert property (port_oe == {{8{!d2[7]}}, {8{d01[4:3] == 2'b00}}, {8{d01[7:6] == 2'b00}}})
    else $error("output enables disagree with direction");
  off_follow_a:
    assert property (!p2en |-> hs_out[2] == aux[6])
    else $error("idle line differs from aux output bit");
  ack_return_a:
    assert property (p2o && port2_request |=> hs_out[2])
    else $error("strobe not returned high after ack fall");
  // Strobe falls two edges after the synchronised level; that level is one of the two raw samples before it
  strobe_defer_a:
    assert property (p2o && $fell(hs_out[2]) |-> $past(hs_in[2], 4) || $past(hs_in[2], 5))
    else $error("strobe fell while ack low");
  strobe_go_a:
    assert property (p2o && wr && addr == pph_pkg::OFS_PORT2 && hs_in[2] && $past(hs_in[2])
      && $past(hs_in[2], 2) && $past(hs_in[2], 3) && $past(hs_in[2], 4) |-> ##[1:3] !hs_out[2])
    else $error("strobe not driven low after write");
  req_single_a:
    assert property (port2_request |=> !port2_request)
    else $error("request longer than one cycle");
  req_enabled_a:
    assert property (port2_request |-> p2en)
    else $error("request while handshake off");
  in_ready_a:
    assert property (p0i && port0_request |=> !hs_out[0])
    else $error("ready not dropped after input strobe");
endmodule // pph_checker

bind pph_top pph_checker pph_checker_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
  .hs_in(hs_in), .hs_out(hs_out), .port_oe(port_oe), .port0_request(port0_request),
  .port2_request(port2_request));

// ==== testbench.sv ====
// Purpose: Register-level tests of the handshake block
// Assumes: Port 2 talks to the peripheral model, port 0 is driven here
// Notes:   Ack is held low before enabling to exercise the deferred strobe
`timescale 1ns/100ps
module testbench;
  logic                       clk;
  logic                       rst;
  logic [pph_pkg::ADDR_W-1:0] addr;
  logic [7:0]                 wdata;
  logic                       wr;
  logic                       rd;
  logic [7:0]                 rdata;
  logic [1:0]                 tb_hs;
  logic                       ack;
  logic [2:0]                 hs_out;
  logic [23:0]                port_in;
  logic [23:0]                port_out;
  logic [23:0]                port_oe;
  logic [2:0]                 req;
  logic                       irq;
  logic                       hold;
  logic                       slow;
  logic [7:0]                 got;
  int                         err_total;
  int                         samples_checked;
  pph_top pph_top_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .hs_in({ack, tb_hs}), .hs_out(hs_out), .port_in(port_in), .port_out(port_out), .port_oe(port_oe),
    .port0_request(req[0]), .port1_request(req[1]), .port2_request(req[2]), .irq(irq));
  pph_periph pph_periph_i (.clk(clk), .rst(rst), .strobe_n(hs_out[2]), .data(port_out[23:16]),
    .hold(hold), .slow(slow), .ack(ack), .got(got));
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    #1;
  endtask
  task automatic get(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    check(rdata, e);
  endtask
  task automatic wait_req(input int n);
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk);
      #1;
      if (req[n] === 1'b1)
        break;
    end
    check(req[n], 1'b1);
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #100us;
    err_total++;
    summarize();
  end
  initial
  begin
    rst = 1'b1;
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    tb_hs = 2'b11;
    port_in = 24'h000000;
    hold = 1'b0;
    slow = 1'b0;
    err_total = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    check(hs_out, 24'h000007);
    get(pph_pkg::OFS_HS_STAT, 8'h3F);
    get(pph_pkg::OFS_P01_DIR, 8'hD8);
    get(4'hF, 8'h00);
    for (int k = 0; k < 3; k++)
    begin
      put(pph_pkg::OFS_P01_DIR, 8'(8'hC0 | (k << 3)));
      check(port_oe[15:8], k == 0 ? 8'hFF : 8'h00);
    end
    // Line falls on a disabled port must leave no trace
    @(posedge clk);
    tb_hs[1] <= 1'b0;
    repeat (8) @(posedge clk);
    get(pph_pkg::OFS_IRQ_STAT, 8'h00);
    @(posedge clk);
    tb_hs[1] <= 1'b1;
    put(pph_pkg::OFS_P2_DIR, 8'h00);
    check(port_oe[23:16], 8'hFF);
    put(pph_pkg::OFS_IRQ_MASK, 8'h04);
    put(pph_pkg::OFS_AUX_OUT, 8'hFF);
    hold <= 1'b1;
    repeat (6) @(posedge clk);
    put(pph_pkg::OFS_AUX_MODE, 8'h20);
    put(pph_pkg::OFS_PORT2, 8'hA5);
    check(port_out[23:16], 8'hA5);
    repeat (10) @(posedge clk);
    #1;
    check(hs_out[2], 1'b1);
    hold <= 1'b0;
    wait_req(2);
    check(got, 8'hA5);
    // Status bit registers on the edge after the request pulse
    @(posedge clk);
    #1;
    check(hs_out[2], 1'b1);
    check(irq, 1'b1);
    get(pph_pkg::OFS_IRQ_STAT, 8'h04);
    put(pph_pkg::OFS_IRQ_STAT, 8'h04);
    check(irq, 1'b0);
    slow <= 1'b1;
    put(pph_pkg::OFS_IRQ_MASK, 8'h00);
    put(pph_pkg::OFS_PORT2, 8'h3C);
    wait_req(2);
    check(got, 8'h3C);
    check(irq, 1'b0);
    get(pph_pkg::OFS_IRQ_STAT, 8'h04);
    put(pph_pkg::OFS_P01_DIR, 8'h58);
    put(pph_pkg::OFS_AUX_MODE, 8'h24);
    check(port_oe[7:0], 8'h00);
    @(posedge clk);
    port_in[7:0] <= 8'h96;
    tb_hs[0] <= 1'b0;
    wait_req(0);
    @(posedge clk);
    #1;
    check(hs_out[0], 1'b0);
    get(pph_pkg::OFS_PORT0, 8'h96);
    check(hs_out[0], 1'b1);
    @(posedge clk);
    tb_hs[0] <= 1'b1;
    repeat (4) @(posedge clk);
    summarize();
  end
endmodule // testbench
